/* logic/osc_tune_consts.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 8-bit register port, 25 MHz system clock
// Notes:   Definitions only
`ifndef OSC_TUNE_CONSTS_SVH
`define OSC_TUNE_CONSTS_SVH
// Register offsets
`define OFS_CLOCK_CONTROL   8'h8f
`define OFS_OSC_TRIM        8'h90
`define OFS_IRQ_STATUS      8'h91
`define OFS_IRQ_MASK        8'h92
// Field positions in the clock control register
`define SEL_LSB             4
`define SEL_MSB             6
`define STABLE_BIT          2
// Reset values
`define SEL_RESET           3'h0
`define TRIM_RESET          6'h00
`define MASK_RESET          2'h0
// Frequency select codes at the two direct ends
`define SEL_SLOW            3'h0
`define SEL_FAST            3'h7
// Trim code corners (two's complement)
`define TRIM_MAX            6'h1f
`define TRIM_CENTRE         6'h00
`define TRIM_MIN            6'h20
// Falling edges of the requested clock before connecting
`define SWITCH_FALLS        4'h8
// Slow oscillator period and the settling delay
`define SLOW_PERIOD_NS      32000
`define SETTLE_NS           4000000
`define SETTLE_SLOW_CYCLES  (`SETTLE_NS / `SLOW_PERIOD_NS)
// Trim settling times, held by the analog oscillators themselves
`define SLOW_TRIM_CYCLES    8
`define FAST_TRIM_NS        1000000
`define CLK_SYS_NS          40
`define FAST_TRIM_CYCLES    (`FAST_TRIM_NS / `CLK_SYS_NS)
// Interrupt status bits
`define IRQ_SWITCH_DONE     0
`define IRQ_STABLE_SET      1
`endif

/* logic/osc_tune_pkg.sv */
// Purpose: Types shared by the oscillator trim and clock switch block
// Assumes: Constants come from osc_tune_consts.svh
// Notes:   Holds types only
package osc_tune_pkg;
  // One register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // Clock switch sequencer states
  typedef enum logic [1:0] {
    SW_RUN,
    SW_WAIT_OLD,
    SW_HOLD
  } sw_state_t;
endpackage : osc_tune_pkg

/* logic/internal_osc_tune_switch.sv */
// What this block does
// - Six-bit two's-complement trim, zero means calibrated
// - Trim spans +/-12.5 percent, equal steps
// - Slow settles in 8 cycles, fast 1 ms
// - Core keeps running during trim shift
// - No flag marks trim shift completion
// - Trim also retimes watchdog and monitor users
// - Trim bits 7 and 6 read zero
// - Select code picks slow, fast or postscaled
// - Select field writable at any time
// - Wait old falling edge, then hold low
// - Count eight requested falls, then connect
// - Leaving slow clears flag, starts 4 ms
// - Between fast rates flag ends set
// - Stability flag is read-only bit 2
// - Control bits 7,3,1,0 read zero
// - Slow osc runs if selected, timer, watchdog
//
// Purpose: Trim code store and glitch-free internal clock rate switch
// Assumes: Oscillator levels arrive synchronous to clk_sys
// Notes:   Analog oscillators take trim_code_q; their slew is theirs
`timescale 1ns/100ps
`include "osc_tune_consts.svh"

module internal_osc_tune_switch
  import osc_tune_pkg::*;
#(
  parameter int SETTLE_CYCLES = `SETTLE_SLOW_CYCLES
) (
  // Clock, reset, enable
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  // Register port
  input  wire reg_req_t   reg_req,
  output logic [7:0]      rdata_q,
  // Oscillator levels
  input  wire logic       fast_osc_lvl,
  input  wire logic       slow_osc_lvl,
  // Slow oscillator keep-alive requests
  input  wire logic       pwrup_timer_en,
  input  wire logic       watchdog_timer_en,
  // Outputs to oscillators and the core
  output logic [5:0]      trim_code_q,
  output logic            slow_osc_enable_q,
  output logic            clock_output_line_q,
  output logic            irq_q
);

  // Registered state
  logic [2:0]  sel_q;           // Requested select field
  logic [2:0]  cur_sel_q;       // Source now driving the output
  sw_state_t   state_q;         // Switch sequencer
  logic [3:0]  fall_cnt_q;      // Requested-clock falls seen
  logic        stable_q;        // Fast oscillator stable flag
  logic        settling_q;      // Settling delay running
  logic [15:0] settle_cnt_q;    // Slow edges left in delay
  logic [5:0]  post_q;          // Postscaler chain
  logic        fast_prev_q;     // Edge detect history
  logic        slow_prev_q;
  logic        cur_prev_q;
  logic        req_prev_q;
  logic [1:0]  irq_stat_q;      // Sticky events
  logic [1:0]  irq_mask_q;      // Event enables

  // Level of the clock chosen by a select code
  function automatic logic src_level(input logic [2:0] sel, input logic fast,
                                     input logic slow, input logic [5:0] post);
    logic lvl;
    lvl = 1'b0;
    unique case (sel)
      `SEL_SLOW: lvl = slow;                       // 31.25 kHz direct
      `SEL_FAST: lvl = fast;                       // 8 MHz direct
      default:   lvl = post[3'(3'h6 - sel)];       // 4 MHz down to 125 kHz
    endcase
    return lvl;
  endfunction : src_level

  // Address decode
  wire wr_ctrl   = ce & reg_req.wr & (reg_req.addr == `OFS_CLOCK_CONTROL);
  wire wr_trim   = ce & reg_req.wr & (reg_req.addr == `OFS_OSC_TRIM);
  wire wr_stat   = ce & reg_req.wr & (reg_req.addr == `OFS_IRQ_STATUS);
  wire wr_mask   = ce & reg_req.wr & (reg_req.addr == `OFS_IRQ_MASK);
  wire [2:0] wsel = reg_req.wdata[`SEL_MSB:`SEL_LSB];

  // Edge detection on raw and derived clocks
  wire fast_fall = fast_prev_q & ~fast_osc_lvl;
  wire slow_fall = slow_prev_q & ~slow_osc_lvl;
  wire cur_lvl   = src_level(cur_sel_q, fast_osc_lvl, slow_osc_lvl, post_q);
  wire req_lvl   = src_level(sel_q, fast_osc_lvl, slow_osc_lvl, post_q);
  wire cur_fall  = cur_prev_q & ~cur_lvl;
  wire req_fall  = req_prev_q & ~req_lvl;

  // Switch events
  wire sel_change = wr_ctrl & (wsel != sel_q);
  // A new target in the same cycle as the last fall wins: the
  // sequencer restarts its count, so no done event may escape then
  wire sw_done    = ce & (state_q == SW_HOLD) & req_fall & ~sel_change
                    & (fall_cnt_q == `SWITCH_FALLS - 4'h1);
  wire from_slow  = sw_done & (cur_sel_q == `SEL_SLOW) & (sel_q != `SEL_SLOW);
  wire fast_fast  = sw_done & (cur_sel_q != `SEL_SLOW) & (sel_q != `SEL_SLOW);
  wire settle_end = ce & settling_q & slow_fall & (settle_cnt_q == 16'h1);

  // Read mux; unimplemented and unmapped bits read zero
  wire [7:0] ctrl_rd = {1'b0, sel_q, 1'b0, stable_q, 2'b00};
  wire [7:0] trim_rd = {2'b00, trim_code_q};
  wire [7:0] rd_mux  = (reg_req.addr == `OFS_CLOCK_CONTROL) ? ctrl_rd :
                       (reg_req.addr == `OFS_OSC_TRIM)      ? trim_rd :
                       (reg_req.addr == `OFS_IRQ_STATUS)    ? {6'h00, irq_stat_q} :
                       (reg_req.addr == `OFS_IRQ_MASK)      ? {6'h00, irq_mask_q} :
                                                              8'h00;

  // Event set bits
  wire [1:0] irq_set = {settle_end | fast_fast, sw_done};

  // Register writes and read data
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trim_code_q <= `TRIM_RESET;
      irq_mask_q  <= `MASK_RESET;
      rdata_q     <= 8'h00;
    end else if (ce) begin
      // Trim write only retunes; core and sequencer never stall
      // Code goes out unaltered; the oscillators turn it into equal
      // frequency steps and slew to it on their own
      if (wr_trim) trim_code_q <= reg_req.wdata[5:0];
      if (wr_mask) irq_mask_q <= reg_req.wdata[1:0];
      rdata_q <= reg_req.rd ? rd_mux : 8'h00;
    end
  end

  // Sticky status, set wins over write-one-to-clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_stat_q <= 2'h0;
      irq_q      <= 1'b0;
    end else if (ce) begin
      irq_stat_q <= (irq_stat_q & ~(wr_stat ? reg_req.wdata[1:0] : 2'h0)) | irq_set;
      irq_q      <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Postscaler and edge history
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      post_q      <= 6'h00;
      fast_prev_q <= 1'b0;
      slow_prev_q <= 1'b0;
      cur_prev_q  <= 1'b0;
      req_prev_q  <= 1'b0;
    end else if (ce) begin
      // Each stage halves on a falling fast edge
      if (fast_fall) post_q <= post_q + 6'h01;
      fast_prev_q <= fast_osc_lvl;
      slow_prev_q <= slow_osc_lvl;
      cur_prev_q  <= cur_lvl;
      // A select write swaps the requested source under the history
      // bit; clearing it drops one doubtful fall rather than invent one
      req_prev_q  <= wr_ctrl ? 1'b0 : req_lvl;
    end
  end

  // Switch sequencer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel_q      <= `SEL_RESET;
      cur_sel_q  <= `SEL_RESET;
      state_q    <= SW_RUN;
      fall_cnt_q <= 4'h0;
    end else if (ce) begin
      if (wr_ctrl) sel_q <= wsel;
      unique case (state_q)
        SW_RUN: begin
          if (sel_change) state_q <= SW_WAIT_OLD;
        end
        SW_WAIT_OLD: begin
          // Old source falls: output is forced low from here
          if (cur_fall) begin
            state_q    <= SW_HOLD;
            fall_cnt_q <= 4'h0;
          end
        end
        SW_HOLD: begin
          // A new request restarts the count on its own clock
          if (sel_change) begin
            fall_cnt_q <= 4'h0;
          end else if (sw_done) begin
            cur_sel_q <= sel_q;
            state_q   <= SW_RUN;
          end else if (req_fall) begin
            fall_cnt_q <= fall_cnt_q + 4'h1;
          end
        end
      endcase
    end
  end

  // Clock output: follows the old source until its fall, then low
  // Gating before that fall would chop a high phase into a runt pulse
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clock_output_line_q <= 1'b0;
    end else if (ce) begin
      clock_output_line_q <= (state_q == SW_HOLD) ? 1'b0 : cur_lvl;
    end
  end

  // Stability flag and settling delay on slow edges
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stable_q     <= 1'b0;
      settling_q   <= 1'b0;
      settle_cnt_q <= 16'h0;
    end else if (ce) begin
      if (from_slow) begin
        // Core runs on at the unsettled rate meanwhile
        stable_q     <= 1'b0;
        settling_q   <= 1'b1;
        settle_cnt_q <= 16'(SETTLE_CYCLES);
      end else if (fast_fast) begin
        stable_q   <= 1'b1;
        settling_q <= 1'b0;
      end else if (settle_end) begin
        stable_q   <= 1'b1;
        settling_q <= 1'b0;
      end else if (settling_q & slow_fall) begin
        settle_cnt_q <= settle_cnt_q - 16'h1;
      end
    end
  end

  // Slow oscillator keep-alive; trim changes its rate for all users
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slow_osc_enable_q <= 1'b1;
    end else if (ce) begin
      slow_osc_enable_q <= (sel_q == `SEL_SLOW) | (cur_sel_q == `SEL_SLOW)
                           | pwrup_timer_en | watchdog_timer_en;
    end
  end

  // Checks
  sequence s_hold_end;
    ce && state_q == SW_HOLD && req_fall && !sel_change
    && fall_cnt_q == `SWITCH_FALLS - 4'h1;
  endsequence

  // Old source seen falling while the switch waits for it
  sequence s_old_fall;
    ce && state_q == SW_WAIT_OLD && cur_fall;
  endsequence

  a_trim_upper_zero: assert property (@(posedge clk_sys) disable iff (rst)
    ce && reg_req.rd && reg_req.addr == `OFS_OSC_TRIM |=> rdata_q[7:6] == 2'b00)
    else $error("trim upper bits not zero");

  a_ctrl_unimpl_zero: assert property (@(posedge clk_sys) disable iff (rst)
    ce && reg_req.rd && reg_req.addr == `OFS_CLOCK_CONTROL
    |=> rdata_q[7] == 1'b0 && rdata_q[3] == 1'b0 && rdata_q[1:0] == 2'b00)
    else $error("control unimplemented bits not zero");

  a_flag_readback: assert property (@(posedge clk_sys) disable iff (rst)
    ce && reg_req.rd && reg_req.addr == `OFS_CLOCK_CONTROL
    |=> rdata_q[`STABLE_BIT] == $past(stable_q))
    else $error("stable flag readback wrong");

  a_switch_start: assert property (@(posedge clk_sys) disable iff (rst)
    ce && state_q == SW_RUN && sel_change |=> state_q == SW_WAIT_OLD)
    else $error("select change did not start switch");

  a_hold_low_out: assert property (@(posedge clk_sys) disable iff (rst)
    ce && state_q == SW_HOLD |=> clock_output_line_q == 1'b0)
    else $error("clock output not held low");

  a_eight_falls: assert property (@(posedge clk_sys) disable iff (rst)
    s_hold_end |=> state_q == SW_RUN && cur_sel_q == $past(sel_q))
    else $error("switch did not connect after eight falls");

  a_leave_slow: assert property (@(posedge clk_sys) disable iff (rst)
    from_slow |=> !stable_q && settling_q && settle_cnt_q == 16'(SETTLE_CYCLES))
    else $error("settling not started on leaving slow");

  a_fast_stays: assert property (@(posedge clk_sys) disable iff (rst)
    s_hold_end ##0 fast_fast |=> stable_q && !settling_q)
    else $error("flag not set after fast switch");

  a_settle_done: assert property (@(posedge clk_sys) disable iff (rst)
    settle_end |=> stable_q ##1 irq_stat_q[`IRQ_STABLE_SET])
    else $error("settling end did not set flag");

  a_trim_no_stall: assert property (@(posedge clk_sys) disable iff (rst)
    ce && wr_trim && state_q == SW_RUN && !sel_change |=> state_q == SW_RUN)
    else $error("trim write disturbed switching");

  a_slow_keepalive: assert property (@(posedge clk_sys) disable iff (rst)
    ce && (watchdog_timer_en || pwrup_timer_en) |=> slow_osc_enable_q)
    else $error("slow oscillator not kept running");

  // Trim store, select store and the clock enable
  a_trim_write: assert property (@(posedge clk_sys) disable iff (rst)
    wr_trim |=> {2'b00, trim_code_q} == ($past(reg_req.wdata) & 8'h3f))
    else $error("trim code not taken from write");

  a_trim_held: assert property (@(posedge clk_sys) disable iff (rst)
    !wr_trim |=> $stable(trim_code_q))
    else $error("trim code moved without a write");

  a_sel_immediate: assert property (@(posedge clk_sys) disable iff (rst)
    wr_ctrl |=> sel_q == $past(wsel))
    else $error("select field not stored");

  a_ce_freeze: assert property (@(posedge clk_sys) disable iff (rst)
    !ce |=> $stable(state_q) && $stable(sel_q) && $stable(trim_code_q)
    && $stable(rdata_q) && $stable(irq_q))
    else $error("state moved with clock enable low");

  // Switch steps seen from the clock output
  a_follow_old: assert property (@(posedge clk_sys) disable iff (rst)
    ce && state_q == SW_WAIT_OLD |=> clock_output_line_q == $past(cur_lvl))
    else $error("output not following old source");

  a_old_fall_hold: assert property (@(posedge clk_sys) disable iff (rst)
    s_old_fall |=> state_q == SW_HOLD ##1 clock_output_line_q == 1'b0)
    else $error("old source fall did not start hold");

  // Settling count and events
  a_settle_count: assert property (@(posedge clk_sys) disable iff (rst)
    ce && settling_q && slow_fall && settle_cnt_q != 16'h1 && !from_slow && !fast_fast
    |=> settle_cnt_q == $past(settle_cnt_q) - 16'h1)
    else $error("settling count not stepped on slow fall");

  a_set_wins: assert property (@(posedge clk_sys) disable iff (rst)
    sw_done |=> irq_stat_q[`IRQ_SWITCH_DONE])
    else $error("switch done event lost");

  a_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
    ce && (irq_stat_q & irq_mask_q) != 2'h0 |=> irq_q)
    else $error("interrupt low with unmasked status");

endmodule : internal_osc_tune_switch

/* dv/testbench.sv */
// Purpose: Self-checking bench for trim store and clock rate switch
// Assumes: Oscillator levels made here, scaled, synchronous to clk_sys
// Notes:   Settling shortened through SETTLE_CYCLES
`timescale 1ns/100ps
`include "osc_tune_consts.svh"

module testbench
  import osc_tune_pkg::*;
;
  localparam int SETTLE = 3;     // Slow falls of settling in sim

  logic       clk_sys;           // System clock
  logic       rst;               // Async reset
  logic       ce;                // Clock enable
  reg_req_t   reg_req;           // Register request
  logic [7:0] rdata_q;           // Read data
  logic       fast_osc_lvl = 1'b0; // Fast level, period 4 clocks
  logic       slow_osc_lvl = 1'b0; // Slow level, period 16 clocks
  logic       pwrup_timer_en;    // Keep-alive from power-up timer
  logic       watchdog_timer_en; // Keep-alive from watchdog
  logic [5:0] trim_code_q;       // Trim to oscillators
  logic       slow_osc_enable_q; // Slow run request
  logic       clock_output_line_q; // Selected clock
  logic       irq_q;             // Interrupt
  logic [3:0] osc_cnt_q = 4'h0;  // Source of both levels
  logic [7:0] rd_val;            // Last read result
  int         err_total;         // Mismatches
  int         samples_checked;   // Comparisons

  internal_osc_tune_switch #(.SETTLE_CYCLES(SETTLE)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_req(reg_req), .rdata_q(rdata_q),
    .fast_osc_lvl(fast_osc_lvl), .slow_osc_lvl(slow_osc_lvl),
    .pwrup_timer_en(pwrup_timer_en), .watchdog_timer_en(watchdog_timer_en),
    .trim_code_q(trim_code_q), .slow_osc_enable_q(slow_osc_enable_q),
    .clock_output_line_q(clock_output_line_q), .irq_q(irq_q));

  // 25 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Free-running oscillator levels, changed after the edge
  always @(posedge clk_sys) begin
    osc_cnt_q <= osc_cnt_q + 4'h1;
    fast_osc_lvl <= osc_cnt_q[1];
    slow_osc_lvl <= osc_cnt_q[3];
  end

  // One compare for every kind of result
  task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  // Single-cycle write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge clk_sys);
    reg_req.wr <= 1'b0;
  endtask : wr

  // Read, data valid only in the next cycle
  task automatic bus_rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge clk_sys);
    reg_req.rd <= 1'b0;
    #1 rd_val = rdata_q;
  endtask : bus_rd

  task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
    bus_rd(a);
    cmp(name, exp, rd_val);
  endtask : rd

  // Bounded wait for an irq level, keeping the longest low output run
  task automatic wait_irq(input logic lvl, output int lows);
    int n;
    int run;
    lows = 0;
    run = 0;
    for (n = 0; n < 400 && irq_q !== lvl; n++) begin
      @(posedge clk_sys);
      #1 run = (clock_output_line_q === 1'b0) ? run + 1 : 0;
      if (run > lows) lows = run;
    end
    cmp("irq_q", {7'h0, lvl}, {7'h0, irq_q});
  endtask : wait_irq

  // Reset values, unmapped read
  task automatic t_reset();
    rd("ctrl", `OFS_CLOCK_CONTROL, 8'h00);
    rd("trim", `OFS_OSC_TRIM, 8'h00);
    rd("unmapped", 8'h8e, 8'h00);
    cmp("slow_en", 8'h01, {7'h0, slow_osc_enable_q});
  endtask : t_reset

  // Trim corners, upper bits, no completion event, ce low
  task automatic t_trim();
    logic [7:0] w[4] = '{8'hff, 8'h20, 8'h1f, 8'h00};
    foreach (w[i]) begin
      wr(`OFS_OSC_TRIM, w[i]);
      rd("trim", `OFS_OSC_TRIM, w[i] & 8'h3f);
      cmp("trim_code_q", w[i] & 8'h3f, {2'h0, trim_code_q});
    end
    rd("status", `OFS_IRQ_STATUS, 8'h00);
    @(posedge clk_sys) ce <= 1'b0;
    wr(`OFS_OSC_TRIM, 8'h15);
    ce <= 1'b1;
    rd("trim_ce", `OFS_OSC_TRIM, 8'h00);
  endtask : t_trim

  // Leave slow for fast: hold low, flag cleared, then settles
  task automatic t_leave_slow();
    int lows;
    wr(`OFS_IRQ_MASK, 8'h03);
    wr(`OFS_CLOCK_CONTROL, 8'hff);
    rd("ctrl", `OFS_CLOCK_CONTROL, 8'h70);
    wait_irq(1'b1, lows);
    cmp("low_span", 8'h01, {7'h0, lows >= 28});
    rd("status", `OFS_IRQ_STATUS, 8'h01);
    rd("ctrl", `OFS_CLOCK_CONTROL, 8'h70);
    wr(`OFS_IRQ_STATUS, 8'h01);
    wait_irq(1'b0, lows);
    wait_irq(1'b1, lows);
    rd("ctrl", `OFS_CLOCK_CONTROL, 8'h74);
    wr(`OFS_IRQ_STATUS, 8'h02);
    cmp("slow_en", 8'h00, {7'h0, slow_osc_enable_q});
    watchdog_timer_en <= 1'b1;
    repeat (3) @(posedge clk_sys);
    cmp("slow_en_wd", 8'h01, {7'h0, slow_osc_enable_q});
    watchdog_timer_en <= 1'b0;
    pwrup_timer_en <= 1'b1;
    repeat (3) @(posedge clk_sys);
    cmp("slow_en_pt", 8'h01, {7'h0, slow_osc_enable_q});
    pwrup_timer_en <= 1'b0;
  endtask : t_leave_slow

  // Fast to fast with target replaced mid-switch
  task automatic t_fast_to_fast();
    int lows;
    wr(`OFS_CLOCK_CONTROL, 8'h50);
    rd("ctrl", `OFS_CLOCK_CONTROL, 8'h54);
    wr(`OFS_CLOCK_CONTROL, 8'h40);
    wait_irq(1'b1, lows);
    rd("ctrl", `OFS_CLOCK_CONTROL, 8'h44);
    rd("status", `OFS_IRQ_STATUS, 8'h03);
    wr(`OFS_IRQ_STATUS, 8'h03);
    wait_irq(1'b0, lows);
  endtask : t_fast_to_fast

  // Into slow with irq masked, then back out
  task automatic t_slow_round();
    int n;
    int lows;
    wr(`OFS_IRQ_MASK, 8'h00);
    wr(`OFS_CLOCK_CONTROL, 8'h00);
    rd_val = 8'h00;
    for (n = 0; n < 100 && rd_val[0] !== 1'b1; n++) bus_rd(`OFS_IRQ_STATUS);
    cmp("switch_done", 8'h01, rd_val & 8'h01);
    cmp("irq_masked", 8'h00, {7'h0, irq_q});
    rd("ctrl", `OFS_CLOCK_CONTROL, 8'h04);
    cmp("slow_en", 8'h01, {7'h0, slow_osc_enable_q});
    wr(`OFS_IRQ_MASK, 8'h01);
    wait_irq(1'b1, lows);
    wr(`OFS_IRQ_STATUS, 8'h03);
    wait_irq(1'b0, lows);
    wr(`OFS_IRQ_MASK, 8'h03);
    wr(`OFS_CLOCK_CONTROL, 8'h60);
    wait_irq(1'b1, lows);
    // Eight falls of the 8-clock half-rate source, seen up to the irq
    cmp("low_run", 8'h01, {7'h0, lows >= 59 && lows <= 66});
    rd("ctrl", `OFS_CLOCK_CONTROL, 8'h60);
  endtask : t_slow_round

  // Verdict and end of run
  task automatic finish_test();
    $display("errors %0d comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // Hang guard, well beyond the expected run of under a thousand cycles
  initial begin
    #(40 * 20000);
    err_total++;
    finish_test();
  end

  // Main sequence
  initial begin
    err_total = 0;
    samples_checked = 0;
    rst = 1'b1;
    ce = 1'b1;
    reg_req = '0;
    pwrup_timer_en = 1'b0;
    watchdog_timer_en = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_trim();
    t_leave_slow();
    t_fast_to_fast();
    t_slow_round();
    finish_test();
  end
endmodule : testbench
